/* File: dpr_cfg.svh */
/*
  Constants for the synchronous dual-port RAM port and its bus controller.
  Assumes it is included by bare name and holds definitions only.
*/
// Summary of operation
// - Inputs registered on rising edge; write self-timed
// - Array write runs apart from capture edge
// - Output enable gates drivers without clock
// - Output state follows previous cycle controls
// - Address load low loads external address
// - Internal address external or counter value
// - Advance increments address, access at new
// - Load and advance high hold counter
// - Counter clear accesses location zero immediately
// - Deselected port powers down its circuitry
// - Pipelined mode needs two selected cycles
// - Bank bit drives opposite chip selects
// - Parallel devices widen data word
// - Rewrite location after read-write idle cycle
// - Latency select: high pipelined, low flow-through
// - Disabled byte stays high impedance on read
// - Deselect floats outputs after next edge
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_ADDR_W 13
`define DPR_DATA_W 18
// Controller register offsets
`define DPR_REG_CMD 3'h0
`define DPR_REG_ADDR 3'h1
`define DPR_REG_WDATA 3'h2
`define DPR_REG_CTRL 3'h3
`define DPR_REG_STATUS 3'h4
`define DPR_REG_RDATA 3'h5
// Command codes in CMD[2:0]
`define DPR_OP_READ 3'h1
`define DPR_OP_WRITE 3'h2
`define DPR_OP_CLR_READ 3'h3
`define DPR_OP_NEXT_READ 3'h4
// CTRL fields and reset value
`define DPR_CTRL_LAT 0
`define DPR_CTRL_UB_N 1
`define DPR_CTRL_LB_N 2
`define DPR_CTRL_RST 3'h0
// STATUS fields
`define DPR_STAT_BUSY 0
`define DPR_STAT_DONE 1
// Bank modes
`define DPR_BANK_NONE 2'h0
`define DPR_BANK_ON_LOW 2'h1
`define DPR_BANK_ON_HIGH 2'h2
`endif

/* File: dpr_checker.sv */
/*
  Checks on the pin bundle between the controller and RAM port A.
  Assumes one clock domain; the bundle signals are wired in by name.
*/
`timescale 1ns/100ps
module dpr_checker
(
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic write_n,
  input wire logic address_load_n,
  input wire logic counter_advance_n,
  input wire logic counter_clear_n,
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic output_enable_n,
  input wire logic output_latency_select,
  input wire logic ctl_dq_oe,
  input wire logic [1:0] dev_dq_oe
);
  // Decoded select; a hold cycle moves no address
  wire sel = ~chip_select_active_low & chip_select_active_high;
  wire hold = address_load_n & counter_advance_n & counter_clear_n;
  wire lat = output_latency_select;
  wire rd = sel & write_n;
  wire wr = sel & ~write_n;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);
  // Device drivers
  float_deselect_a:
    assert property (!sel |=> dev_dq_oe == 2'h0) else $error("drive after deselect");
  oe_async_gate_a:
    assert property (output_enable_n |-> dev_dq_oe == 2'h0) else $error("drive with output enable off");
  ft_read_drive_a:
    assert property (rd && !lat ##1 !lat && !output_enable_n
      |-> dev_dq_oe == {~$past(upper_byte_enable_n), ~$past(lower_byte_enable_n)}) else $error("flow lanes");
  pipe_read_drive_a:
    assert property (rd && lat ##1 rd && lat ##1 lat && !output_enable_n
      |-> dev_dq_oe == {~$past(upper_byte_enable_n, 2), ~$past(lower_byte_enable_n, 2)}) else $error("pipe lanes");
  ft_write_quiet_a:
    assert property (wr && !lat ##1 !lat |-> dev_dq_oe == 2'h0) else $error("drive after write");
  // Controller side; contention is avoided by gating the device off
  write_drive_a:
    assert property (wr |-> ctl_dq_oe && output_enable_n) else $error("write data not driven");
  read_gap_a:
    assert property (wr |-> !$past(sel) || !$past(write_n)) else $error("write right after read");
  pipe_hold_a:
    assert property (rd && lat && !hold |=> rd && hold) else $error("no second selected cycle");
  // Main scenarios seen
  ft_read_c: cover property (rd && !lat);
  pipe_read_c: cover property (rd && lat ##1 rd);
  write_c: cover property (wr);
  clear_c: cover property (rd && !counter_clear_n);
endmodule : dpr_checker

/* File: dpr_ctl.sv */
/*
  Bus controller for one RAM port, ordered through a small register port.
  Assumes the RAM port shares I_REF_CLK and the pin bundle.
*/
`timescale 1ns/100ps
`include "dpr_cfg.svh"
module dpr_ctl
  import dpr_pkg::*;
#(
  parameter int ADDR_W = `DPR_ADDR_W,
  parameter int DATA_W = `DPR_DATA_W,
  parameter logic [1:0] BANK_MODE = `DPR_BANK_NONE
)
(
  dpr_if.ctl bus,
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [2:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA
);
  // wide words come from parallel devices, each at most 32 bits here
  if (DATA_W > 32 || (DATA_W % 2) != 0 || ADDR_W > 30 || BANK_MODE > 2'h2)
  begin : gen_bad_params
    $error("dpr_ctl: unsupported parameters");
  end

  dpr_state_t state_ff, nxt_state;
  logic [ADDR_W:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff, dq_out_ff;
  logic [2:0] ctrl_ff, op_ff;
  logic done_ff, last_rd_ff;
  logic cs_low_ff, cs_high_ff, wr_n_ff, ld_n_ff, adv_n_ff, clr_n_ff, dq_oe_ff;
  logic [31:0] rdata_out_ff;

  // Command decode
  wire cmd_wr = I_REG_WR & (I_REG_ADDR == `DPR_REG_CMD);
  wire [2:0] cmd_op = I_REG_WDATA[2:0];
  wire op_ok = (cmd_op >= `DPR_OP_READ) && (cmd_op <= `DPR_OP_NEXT_READ);
  wire go = (state_ff == ST_IDLE) & cmd_wr & op_ok;
  wire [2:0] cur_op = (state_ff == ST_IDLE) ? cmd_op : op_ff;
  wire is_wr = (cur_op == `DPR_OP_WRITE);
  wire lat = ctrl_ff[`DPR_CTRL_LAT];
  wire need_gap = go & is_wr & last_rd_ff;
  wire ent_issue = (go & ~need_gap) | (state_ff == ST_GAP);
  wire hold_sel = (state_ff == ST_ISSUE) & ~is_wr & lat;
  wire take = ((state_ff == ST_HOLD) & ~lat) | (state_ff == ST_TAKE);
  wire act = ent_issue | hold_sel;
  wire bank = addr_ff[ADDR_W];
  // bank bit on one chip select
  wire nxt_cs_low = ~act | ((BANK_MODE == `DPR_BANK_ON_LOW) & bank);
  wire nxt_cs_high = act & ((BANK_MODE != `DPR_BANK_ON_HIGH) | bank);
  wire nxt_ld_n = ~(ent_issue & ((cur_op == `DPR_OP_READ) | is_wr));
  wire nxt_adv_n = ~(ent_issue & (cur_op == `DPR_OP_NEXT_READ));
  wire nxt_clr_n = ~(ent_issue & (cur_op == `DPR_OP_CLR_READ));
  wire nxt_wr_n = ~(ent_issue & is_wr);
  wire done_set = take | ((state_ff == ST_ISSUE) & is_wr);
  wire done_clr = I_REG_RD & (I_REG_ADDR == `DPR_REG_STATUS);
  wire busy = (state_ff != ST_IDLE);

  // Sequence
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (go) nxt_state = need_gap ? ST_GAP : ST_ISSUE;
      ST_GAP: nxt_state = ST_ISSUE;
      ST_ISSUE: nxt_state = is_wr ? ST_IDLE : ST_HOLD;
      ST_HOLD: nxt_state = lat ? ST_TAKE : ST_IDLE;
      ST_TAKE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Register read mux, answered one cycle later
  wire [31:0] nxt_rdata_out =
    (I_REG_ADDR == `DPR_REG_ADDR) ? 32'(addr_ff) :
    (I_REG_ADDR == `DPR_REG_WDATA) ? 32'(wdata_ff) :
    (I_REG_ADDR == `DPR_REG_CTRL) ? {29'h0, ctrl_ff} :
    (I_REG_ADDR == `DPR_REG_STATUS) ? {30'h0, done_ff, busy} :
    (I_REG_ADDR == `DPR_REG_RDATA) ? 32'(rdata_ff) : 32'h0;

  // Software registers; writes while busy would tear a transfer
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_ff <= ST_IDLE;
      addr_ff <= '0;
      wdata_ff <= '0;
      ctrl_ff <= `DPR_CTRL_RST;
      op_ff <= 3'h0;
      rdata_ff <= '0;
      done_ff <= 1'b0;
      last_rd_ff <= 1'b0;
      rdata_out_ff <= 32'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (I_REG_WR && !busy && I_REG_ADDR == `DPR_REG_ADDR) addr_ff <= I_REG_WDATA[ADDR_W:0];
      if (I_REG_WR && !busy && I_REG_ADDR == `DPR_REG_WDATA) wdata_ff <= I_REG_WDATA[DATA_W-1:0];
      if (I_REG_WR && !busy && I_REG_ADDR == `DPR_REG_CTRL) ctrl_ff <= I_REG_WDATA[2:0];
      if (go) op_ff <= cmd_op;
      if (take) rdata_ff <= bus.dq;
      // Set wins over the status-read clear
      done_ff <= done_set | (done_ff & ~done_clr);
      if (state_ff == ST_ISSUE) last_rd_ff <= ~is_wr;
      rdata_out_ff <= I_REG_RD ? nxt_rdata_out : 32'h0;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      cs_low_ff <= 1'b1;
      cs_high_ff <= 1'b0;
      wr_n_ff <= 1'b1;
      ld_n_ff <= 1'b1;
      adv_n_ff <= 1'b1;
      clr_n_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      dq_out_ff <= '0;
    end
    else
    begin
      cs_low_ff <= nxt_cs_low;
      cs_high_ff <= nxt_cs_high;
      wr_n_ff <= nxt_wr_n;
      ld_n_ff <= nxt_ld_n;
      adv_n_ff <= nxt_adv_n;
      clr_n_ff <= nxt_clr_n;
      dq_oe_ff <= ~nxt_wr_n;
      dq_out_ff <= wdata_ff;
    end
  end

  assign bus.addr = addr_ff[ADDR_W-1:0];
  assign bus.write_n = wr_n_ff;
  assign bus.address_load_n = ld_n_ff;
  assign bus.counter_advance_n = adv_n_ff;
  assign bus.counter_clear_n = clr_n_ff;
  assign bus.chip_select_active_low = cs_low_ff;
  assign bus.chip_select_active_high = cs_high_ff;
  assign bus.upper_byte_enable_n = ctrl_ff[`DPR_CTRL_UB_N];
  assign bus.lower_byte_enable_n = ctrl_ff[`DPR_CTRL_LB_N];
  // Device drivers off while we drive a write
  assign bus.output_enable_n = dq_oe_ff;
  assign bus.output_latency_select = lat;
  assign bus.ctl_dq = dq_out_ff;
  assign bus.ctl_dq_oe = dq_oe_ff;
  assign O_REG_RDATA = rdata_out_ff;
endmodule : dpr_ctl

/* File: dpr_if.sv */
/*
  Pin bundle between the bus controller and one RAM port.
  Assumes both ends share I_REF_CLK; the shared data wire is resolved here.
*/
`timescale 1ns/100ps
interface dpr_if #(parameter int ADDR_W = 13, parameter int DATA_W = 18);
  logic [ADDR_W-1:0] addr;
  logic write_n;
  logic address_load_n;
  logic counter_advance_n;
  logic counter_clear_n;
  logic chip_select_active_low;
  logic chip_select_active_high;
  logic upper_byte_enable_n;
  logic lower_byte_enable_n;
  logic output_enable_n;
  logic output_latency_select;
  logic [DATA_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic [1:0] dev_dq_oe;
  logic [DATA_W-1:0] dq;
  // Wire level per byte; an undriven byte reads as zero
  assign dq[DATA_W/2-1:0] = dev_dq_oe[0] ? dev_dq[DATA_W/2-1:0] :
                            ctl_dq_oe ? ctl_dq[DATA_W/2-1:0] : '0;
  assign dq[DATA_W-1:DATA_W/2] = dev_dq_oe[1] ? dev_dq[DATA_W-1:DATA_W/2] :
                                 ctl_dq_oe ? ctl_dq[DATA_W-1:DATA_W/2] : '0;
  modport dev
  (
    input addr, write_n, address_load_n, counter_advance_n, counter_clear_n,
    input chip_select_active_low, chip_select_active_high,
    input upper_byte_enable_n, lower_byte_enable_n, output_enable_n,
    input output_latency_select, dq,
    output dev_dq, dev_dq_oe
  );
  modport ctl
  (
    output addr, write_n, address_load_n, counter_advance_n, counter_clear_n,
    output chip_select_active_low, chip_select_active_high,
    output upper_byte_enable_n, lower_byte_enable_n, output_enable_n,
    output output_latency_select, ctl_dq, ctl_dq_oe,
    input dq
  );
endinterface : dpr_if

/* File: dpr_pkg.sv */
/*
  Types shared by the controller and the RAM port.
  Assumes dpr_cfg.svh is on the include path.
*/
package dpr_pkg;
  // Controller sequence, Gray along idle-gap-issue-hold-take
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_GAP = 3'h1,
    ST_ISSUE = 3'h3,
    ST_HOLD = 3'h2,
    ST_TAKE = 3'h6
  } dpr_state_t;
  typedef logic [1:0] dpr_be_t;
endpackage : dpr_pkg

/* File: dpr_port.sv */
/*
  RAM array with port A on the pin bundle and port B on plain ports.
  Assumes one clock for both ports; same-address writes from both ports
  in one cycle are a collision, port B then wins.
*/
`timescale 1ns/100ps
`include "dpr_cfg.svh"
module dpr_port
  import dpr_pkg::*;
#(
  parameter int ADDR_W = `DPR_ADDR_W,
  parameter int DATA_W = `DPR_DATA_W
)
(
  dpr_if.dev bus,
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_B_SELECT,
  input wire logic I_B_WRITE,
  input wire logic I_B_ADDRESS_LOAD_N,
  input wire logic I_B_COUNTER_ADVANCE_N,
  input wire logic I_B_COUNTER_CLEAR_N,
  input wire logic [ADDR_W-1:0] I_B_ADDR,
  input wire logic [DATA_W-1:0] I_B_WDATA,
  output logic [DATA_W-1:0] O_B_RDATA,
  output logic O_A_STANDBY,
  output logic O_B_STANDBY
);
  localparam int BYTE_W = DATA_W / 2;
  localparam int DEPTH = 1 << ADDR_W;

  // Odd widths cannot split into two byte lanes; refused at elaboration
  if ((DATA_W % 2) != 0 || DATA_W < 2 || ADDR_W < 1 || ADDR_W > 20)
  begin : gen_bad_params
    $error("dpr_port: unsupported DATA_W or ADDR_W");
  end

  // Next counter value: clear beats load beats advance beats hold
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] cnt,
    input logic [ADDR_W-1:0] ext,
    input logic clr_n,
    input logic ld_n,
    input logic adv_n
  );
    logic [ADDR_W-1:0] r;
    if (!clr_n)
      r = '0;
    else if (!ld_n)
      r = ext;
    else if (!adv_n)
      r = cnt + {{(ADDR_W-1){1'b0}}, 1'b1};
    else
      r = cnt;
    return r;
  endfunction : next_addr

  // Byte-lane merge used for writes and for read-after-write bypass
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] neu,
    input dpr_be_t be
  );
    logic [DATA_W-1:0] r;
    r = old;
    if (be[0])
      r[BYTE_W-1:0] = neu[BYTE_W-1:0];
    if (be[1])
      r[DATA_W-1:BYTE_W] = neu[DATA_W-1:BYTE_W];
    return r;
  endfunction : merge

  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // Port A registered inputs and counter
  logic [ADDR_W-1:0] a_addr_ff;
  logic a_we_ff;
  dpr_be_t a_wbe_ff;
  logic [DATA_W-1:0] a_wdata_ff;
  logic [DATA_W-1:0] a_ft_q_ff;
  dpr_be_t a_ft_oe_ff;
  logic [DATA_W-1:0] a_pipe_q_ff;
  dpr_be_t a_pipe_oe_ff;
  logic a_standby_ff;
  // Port B registered inputs and counter
  logic [ADDR_W-1:0] b_addr_ff;
  logic b_we_ff;
  logic [DATA_W-1:0] b_wdata_ff;
  logic [DATA_W-1:0] b_q_ff;
  logic b_standby_ff;

  // Port A decode
  wire a_sel = ~bus.chip_select_active_low & bus.chip_select_active_high;
  wire dpr_be_t a_be = {~bus.upper_byte_enable_n, ~bus.lower_byte_enable_n};
  wire [ADDR_W-1:0] nxt_a_addr = next_addr(a_addr_ff, bus.addr, bus.counter_clear_n,
                                           bus.address_load_n, bus.counter_advance_n);
  wire a_read = a_sel & bus.write_n;
  wire a_write = a_sel & ~bus.write_n;
  // Pending writes are merged in so a read right after a write sees it
  wire [DATA_W-1:0] a_arr = mem[nxt_a_addr];
  wire a_hit_a = a_we_ff & (a_addr_ff == nxt_a_addr);
  wire a_hit_b = b_we_ff & (b_addr_ff == nxt_a_addr);
  wire [DATA_W-1:0] a_byp = a_hit_a ? merge(a_arr, a_wdata_ff, a_wbe_ff) : a_arr;
  wire [DATA_W-1:0] nxt_a_word = a_hit_b ? b_wdata_ff : a_byp;
  wire dpr_be_t nxt_a_ft_oe = a_read ? a_be : 2'h0;
  // pipelined drive needs the next cycle selected too
  wire dpr_be_t nxt_a_pipe_oe = a_sel ? a_ft_oe_ff : 2'h0;

  // capture port A inputs at the rising edge
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      a_addr_ff <= '0;
      a_we_ff <= 1'b0;
      a_wbe_ff <= 2'h0;
      a_wdata_ff <= '0;
    end
    else
    begin
      a_addr_ff <= nxt_a_addr;
      a_we_ff <= a_write & (a_be != 2'h0);
      a_wbe_ff <= a_be;
      a_wdata_ff <= bus.dq;
    end
  end

  // Port A read data and drive state, one and two stages deep
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      a_ft_q_ff <= '0;
      a_ft_oe_ff <= 2'h0;
      a_pipe_q_ff <= '0;
      a_pipe_oe_ff <= 2'h0;
      a_standby_ff <= 1'b1;
    end
    else
    begin
      // deselected port does no array read
      if (a_sel)
        a_ft_q_ff <= nxt_a_word;
      // drive set by the captured controls
      a_ft_oe_ff <= nxt_a_ft_oe;
      a_pipe_q_ff <= a_ft_q_ff;
      a_pipe_oe_ff <= nxt_a_pipe_oe;
      a_standby_ff <= ~a_sel;
    end
  end

  // port B has its own counter
  wire [ADDR_W-1:0] nxt_b_addr = next_addr(b_addr_ff, I_B_ADDR, I_B_COUNTER_CLEAR_N,
                                           I_B_ADDRESS_LOAD_N, I_B_COUNTER_ADVANCE_N);
  wire [DATA_W-1:0] b_arr = mem[nxt_b_addr];
  wire b_hit_a = a_we_ff & (a_addr_ff == nxt_b_addr);
  wire [DATA_W-1:0] nxt_b_word = b_hit_a ? merge(b_arr, a_wdata_ff, a_wbe_ff) : b_arr;

  // port B registered inputs and flow-through data
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      b_addr_ff <= '0;
      b_we_ff <= 1'b0;
      b_wdata_ff <= '0;
      b_q_ff <= '0;
      b_standby_ff <= 1'b1;
    end
    else
    begin
      b_addr_ff <= nxt_b_addr;
      b_we_ff <= I_B_SELECT & I_B_WRITE;
      b_wdata_ff <= I_B_WDATA;
      if (I_B_SELECT & ~I_B_WRITE)
        b_q_ff <= nxt_b_word;
      b_standby_ff <= ~I_B_SELECT;
    end
  end

  // array write from captured inputs, one edge after capture
  always_ff @(posedge I_REF_CLK)
  begin
    if (a_we_ff)
      mem[a_addr_ff] <= merge(mem[a_addr_ff], a_wdata_ff, a_wbe_ff);
    if (b_we_ff)
      mem[b_addr_ff] <= b_wdata_ff;
  end

  // latency select picks the stage; a static strap, not clocked
  wire [DATA_W-1:0] a_q = bus.output_latency_select ? a_pipe_q_ff : a_ft_q_ff;
  wire dpr_be_t a_oe = bus.output_latency_select ? a_pipe_oe_ff : a_ft_oe_ff;

  // output enable gates drivers with no clock
  assign bus.dev_dq_oe = a_oe & {2{~bus.output_enable_n}};
  assign bus.dev_dq = a_q;
  assign O_B_RDATA = b_q_ff;
  assign O_A_STANDBY = a_standby_ff;
  assign O_B_STANDBY = b_standby_ff;
endmodule : dpr_port

/* File: tb_top.sv */
/*
  Bench: controller and RAM port A joined by the bundle, port B driven here.
  Assumes one shared clock and the controller's register map.
*/
`timescale 1ns/100ps
`include "dpr_cfg.svh"
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic b_sel = 1'b0;
  logic b_wr = 1'b0;
  logic [2:0] b_ctl = 3'h7;
  logic [12:0] b_addr = 13'h0;
  logic [17:0] b_wdata = 18'h0;
  logic [17:0] b_rdata;
  logic a_stby;
  logic b_stby;
  logic [31:0] r;
  logic [31:0] e;
  logic [17:0] q;
  logic [17:0] w;
  logic [12:0] addrs [5] = '{13'h0, 13'h1, 13'h40, 13'h41, 13'h42};
  int errors = 0;
  int compares = 0;

  dpr_if #(.ADDR_W(`DPR_ADDR_W), .DATA_W(`DPR_DATA_W)) bus ();
  dpr_ctl dpr_ctl_i (.bus(bus), .I_REF_CLK(clk), .I_NRST(nrst), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata));
  dpr_port dpr_port_i (.bus(bus), .I_REF_CLK(clk), .I_NRST(nrst), .I_B_SELECT(b_sel), .I_B_WRITE(b_wr),
    .I_B_ADDRESS_LOAD_N(b_ctl[0]), .I_B_COUNTER_ADVANCE_N(b_ctl[1]), .I_B_COUNTER_CLEAR_N(b_ctl[2]),
    .I_B_ADDR(b_addr), .I_B_WDATA(b_wdata), .O_B_RDATA(b_rdata), .O_A_STANDBY(a_stby), .O_B_STANDBY(b_stby));
  dpr_checker dpr_checker_i (.I_REF_CLK(clk), .I_NRST(nrst), .write_n(bus.write_n),
    .address_load_n(bus.address_load_n), .counter_advance_n(bus.counter_advance_n),
    .counter_clear_n(bus.counter_clear_n), .chip_select_active_low(bus.chip_select_active_low),
    .chip_select_active_high(bus.chip_select_active_high), .upper_byte_enable_n(bus.upper_byte_enable_n),
    .lower_byte_enable_n(bus.lower_byte_enable_n), .output_enable_n(bus.output_enable_n),
    .output_latency_select(bus.output_latency_select), .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_oe(bus.dev_dq_oe));

  // Reference clock, 40 ns period
  always #20 clk = ~clk;

  // Distinct word per address, so a wrong address shows
  function automatic logic [17:0] pat(input logic [12:0] a);
    return 18'h2A5A5 ^ {5'h0, a};
  endfunction : pat

  task conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %b", $time, what, got);
    end
  endtask : chk_bit

  // Register port strobes last one cycle; read data stand in the next
  task reg_write(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // One controller order, polled under a bound
  task ctl_op(input logic [2:0] op, input logic [12:0] a, input logic [17:0] d, output logic [31:0] rd);
    logic [31:0] st;
    st = 32'h0;
    reg_write(`DPR_REG_ADDR, {19'h0, a});
    reg_write(`DPR_REG_WDATA, {14'h0, d});
    reg_write(`DPR_REG_CMD, {29'h0, op});
    // Port A is selected in the first cycle after the order, unless a gap comes first
    @(posedge clk);
    #1;
    if (op != `DPR_OP_WRITE)
      chk_bit(a_stby, 1'b0, "A standby while selected");
    for (int n = 0; n < 40 && st[`DPR_STAT_DONE] !== 1'b1; n++)
      reg_read(`DPR_REG_STATUS, st);
    if (st[`DPR_STAT_DONE] !== 1'b1)
    begin
      errors++;
      $display("MISMATCH at %0t: controller never done", $time);
      conclude();
    end
    reg_read(`DPR_REG_RDATA, rd);
  endtask : ctl_op

  // Port B: one access cycle, then a hold read; c is {clear_n, advance_n, load_n}
  task b_acc(input logic wt, input logic [2:0] c, input logic [12:0] a, input logic [17:0] d,
             output logic [17:0] rq);
    @(posedge clk);
    b_sel <= 1'b1;
    b_wr <= wt;
    b_ctl <= c;
    b_addr <= a;
    b_wdata <= d;
    @(posedge clk);
    b_wr <= 1'b0;
    b_ctl <= 3'h7;
    #1 chk_bit(b_stby, 1'b0, "B standby while selected");
    @(posedge clk);
    b_sel <= 1'b0;
    #1 rq = b_rdata;
  endtask : b_acc

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    reg_read(`DPR_REG_CTRL, r);
    chk_word(r, {29'h0, `DPR_CTRL_RST}, "CTRL reset");
    reg_read(3'h7, r);
    chk_word(r, 32'h0, "unmapped read");
    chk_bit(a_stby, 1'b1, "A standby idle");
    $display("test reset done");
    foreach (addrs[i]) b_acc(1'b1, 3'b110, addrs[i], pat(addrs[i]), q);
    b_acc(1'b0, 3'b110, 13'h40, 18'h0, q);
    chk_word({14'h0, q}, {14'h0, pat(13'h40)}, "B load read");
    b_acc(1'b0, 3'b101, 13'h0, 18'h0, q);
    chk_word({14'h0, q}, {14'h0, pat(13'h41)}, "B advance read");
    b_acc(1'b0, 3'b011, 13'h55, 18'h0, q);
    chk_word({14'h0, q}, {14'h0, pat(13'h0)}, "B clear read");
    @(posedge clk);
    #1 chk_bit(b_stby, 1'b1, "B standby idle");
    $display("test port B done");
    w = pat(13'h40);
    for (int c = 0; c < 8; c++)
    begin
      reg_write(`DPR_REG_CTRL, 32'(c));
      ctl_op(`DPR_OP_READ, 13'h40, 18'h0, r);
      e = {14'h0, c[`DPR_CTRL_UB_N] ? 9'h0 : w[17:9], c[`DPR_CTRL_LB_N] ? 9'h0 : w[8:0]};
      chk_word(r, e, "lane read");
    end
    $display("test lanes done");
    for (int m = 0; m < 2; m++)
    begin
      reg_write(`DPR_REG_CTRL, 32'(m));
      ctl_op(`DPR_OP_READ, 13'h40, 18'h0, r);
      chk_word(r, {14'h0, pat(13'h40)}, "load read");
      ctl_op(`DPR_OP_NEXT_READ, 13'h0, 18'h0, r);
      chk_word(r, {14'h0, pat(13'h41)}, "advance read");
      ctl_op(`DPR_OP_CLR_READ, 13'h40, 18'h0, r);
      chk_word(r, {14'h0, pat(13'h0)}, "clear read");
      ctl_op(`DPR_OP_NEXT_READ, 13'h0, 18'h0, r);
      chk_word(r, {14'h0, pat(13'h1)}, "advance after clear");
    end
    $display("test counter done");
    ctl_op(`DPR_OP_WRITE, 13'h41, 18'h3C3C3, r);
    ctl_op(`DPR_OP_WRITE, 13'h42, 18'h0F0F0, r);
    b_acc(1'b0, 3'b110, 13'h41, 18'h0, q);
    chk_word({14'h0, q}, 32'h3C3C3, "A write seen on B");
    ctl_op(`DPR_OP_READ, 13'h42, 18'h0, r);
    chk_word(r, 32'h0F0F0, "A write read back");
    reg_read(`DPR_REG_STATUS, r);
    chk_word(r, 32'h0, "status after done read");
    // An undefined opcode must leave the controller idle
    reg_write(`DPR_REG_CMD, 32'h5);
    reg_read(`DPR_REG_STATUS, r);
    chk_word(r, 32'h0, "bad opcode ignored");
    $display("test writes done");
    conclude();
  end
endmodule : tb_top
